// [core/scas_if.sv]
`timescale 1ns/100ps
`default_nettype none

// link between register core and image loader
interface scas_if;
  logic        strap_valid;
  logic [3:0]  strap_code;
  logic        mem_req;
  logic [15:0] mem_addr;
  logic        mem_ack;
  logic [15:0] mem_data;
  logic        wr_valid;
  logic [1:0]  wr_idx;
  logic [15:0] wr_data;
  logic        done;
  logic        crc_fail;

  modport loader (
    input  strap_valid, strap_code, mem_ack, mem_data,
    output mem_req, mem_addr, wr_valid, wr_idx, wr_data, done, crc_fail
  );
  modport core (
    output strap_valid, strap_code, mem_ack, mem_data,
    input  mem_req, mem_addr, wr_valid, wr_idx, wr_data, done, crc_fail
  );
endinterface

`default_nettype wire

// [core/scas_loader.sv]
`timescale 1ns/100ps
`default_nettype none

module scas_loader
  import scas_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rstn,
  // core side
  scas_if.loader    ifc
);

  typedef struct packed {
    scas_ld_e    st;
    logic        req;
    logic [15:0] addr;
    logic [2:0]  cnt;
    logic [15:0] crc;
    logic        wr;
    logic [1:0]  widx;
    logic [15:0] wdata;
  } scas_ld_s;

  scas_ld_s q, d;

  // ----------------------------------------
  // crc over one 16-bit word, msb first
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [5:0] hdr_ptr;
  logic [3:0] hdr_cnt;
  logic [5:0] img_idx;
  assign hdr_ptr = ifc.mem_data[PTR_LSB +: 6];
  assign hdr_cnt = ifc.mem_data[3:0];
  // single image: pointer names latest image; multi: pointer plus strap code
  assign img_idx = (hdr_cnt > 4'h1) ? 6'(hdr_ptr + {2'b00, ifc.strap_code}) : hdr_ptr;

  // ----------------------------------------
  // load sequence
  // ----------------------------------------
  always_comb begin
    d    = q;
    d.wr = 1'b0;
    unique case (q.st)
      LD_IDLE: begin
        if (ifc.strap_valid) begin
          d.st   = LD_HDR;
          d.req  = 1'b1;
          d.addr = HDR_ADDR;
        end
      end
      LD_HDR: begin
        if (ifc.mem_ack) begin
          d.st   = LD_WORDS;
          d.cnt  = 3'h0;
          d.crc  = CRC_INIT;
          d.addr = 16'(IMG_FIRST_ADDR + 16'(img_idx) * IMG_STRIDE);
        end
      end
      LD_WORDS: begin
        if (ifc.mem_ack) begin
          if (q.cnt < IMG_DATA_WORDS) begin
            d.wr    = 1'b1;
            d.widx  = q.cnt[1:0];
            d.wdata = ifc.mem_data;
            d.crc   = crc_step(q.crc, ifc.mem_data);
            d.cnt   = 3'(q.cnt + 3'h1);
            d.addr  = 16'(q.addr + 16'h0001);
          end else begin
            d.req = 1'b0;
            // mismatch parks the loader; regulator never starts
            d.st  = (ifc.mem_data == q.crc) ? LD_DONE : LD_FAIL;
          end
        end
      end
      LD_DONE: d.req = 1'b0;
      LD_FAIL: d.req = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{st: LD_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ifc.mem_req  = q.req;
  assign ifc.mem_addr = q.addr;
  assign ifc.wr_valid = q.wr;
  assign ifc.wr_idx   = q.widx;
  assign ifc.wr_data  = q.wdata;
  assign ifc.done     = (q.st == LD_DONE);
  assign ifc.crc_fail = (q.st == LD_FAIL);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_hdr_first: assert property ((q.st == LD_IDLE) && ifc.strap_valid |=>
    q.req && (q.addr == HDR_ADDR)) else $error("header not fetched first");
  a_multi_select: assert property ((q.st == LD_HDR) && ifc.mem_ack && (hdr_cnt > 4'h1) |=>
    q.addr == 16'(IMG_FIRST_ADDR + 16'($past(hdr_ptr) + $past(ifc.strap_code)) * IMG_STRIDE))
    else $error("multi image index wrong");
  a_single_select: assert property ((q.st == LD_HDR) && ifc.mem_ack && (hdr_cnt <= 4'h1) |=>
    q.addr == 16'(IMG_FIRST_ADDR + 16'($past(hdr_ptr)) * IMG_STRIDE))
    else $error("single image not latest");
  c_multi_load: cover property ((q.st == LD_HDR) && ifc.mem_ack && (hdr_cnt > 4'h1));

endmodule

`default_nettype wire

// [core/scas_pkg.sv]
package scas_pkg;

  // ----------------------------------------
  // register offsets and field positions
  // ----------------------------------------
  localparam logic [7:0]  REG_TARGET_ADDR = 8'h40;
  localparam logic [7:0]  REG_OFFSET_CTRL = 8'h42;
  localparam logic [7:0]  REG_LFZ_IDX1_4  = 8'h62;
  localparam logic [7:0]  REG_LFZ_IDX0    = 8'h64;
  localparam int          OFFDIS_BIT      = 6;
  localparam int          LFZ_IDX0_LSB    = 12;
  localparam int          LFZ_FIELD_PITCH = 4;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [6:0]  RST_BASE_ADDR   = 7'h10;
  localparam logic        RST_OFFDIS      = 1'b0;
  localparam logic [2:0]  RST_LFZ_CAP [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};

  // ----------------------------------------
  // strap decode and image store layout
  // ----------------------------------------
  localparam logic [3:0]  MAX_PIN_OFFSET  = 4'h4;
  localparam logic [15:0] HDR_ADDR        = 16'h0000;
  localparam int          PTR_LSB         = 8;
  localparam logic [15:0] IMG_FIRST_ADDR  = 16'h0001;
  localparam logic [15:0] IMG_STRIDE      = 16'h0005;
  localparam logic [2:0]  IMG_DATA_WORDS  = 3'h4;
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;

  // current-limit strap code to filter-zero index
  localparam logic [2:0]  CURRENT_LIMIT_STRAP_PIN_LFZ_IDX [16] = '{
    3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
    3'h3, 3'h4, 3'h1, 3'h3, 3'h2, 3'h3, 3'h1, 3'h3};

  typedef enum logic [4:0] {
    LD_IDLE  = 5'b00001,
    LD_HDR   = 5'b00010,
    LD_WORDS = 5'b00100,
    LD_DONE  = 5'b01000,
    LD_FAIL  = 5'b10000
  } scas_ld_e;

endpackage

// [core/scas_top.sv]
// Functional notes
// - filter zero capacitance settable 1 to 8 pF in 1 pF steps via 3-bit field
// - strap-chosen filter zero leaves the overcurrent threshold selection untouched
// - per-index fields replace default capacitance for filter-zero indices zero to four
// - address strap decodes to sixteen codes, short zero, open fifteen
// - strap offset applies to the target address of both I2C and PMBus
// - at power-up, with a multi-image store, strap code chooses one of sixteen stored images
// - pin-derived address offset limited to at most four
// - single-image store loads the most recently programmed image regardless of strap
// - multi-image store loads the image indexed by the strap code
// - offset-disable bit set makes the device ignore the strap offset
// - with offset disabled, target address equals the seven-bit base field
// - offsets of five or more only reachable with the disable bit set
// - stored configuration copied, crc checked, regulator held off on failure
// - multi-image start pointer and image count come from the header word
`timescale 1ns/100ps
`default_nettype none

module scas_top
  import scas_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // strap comparator outputs, thermometer coded
  input  wire logic [14:0] i_strap_select_pin,
  input  wire logic [14:0] i_current_limit_strap_pin,
  // register port from the bus engine
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // rewritable image store read port
  output logic             o_mem_req,
  output logic [15:0]      o_mem_addr,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_data,
  // operating outputs
  output logic [6:0]       o_target_addr,
  output logic [2:0]       o_loop_filter_zero_cap,
  output logic [3:0]       o_overcurrent_limit_sel,
  output logic             o_load_done,
  output logic             o_crc_fail,
  output logic             o_regulator_en
);

  typedef struct packed {
    logic            strap_taken;
    logic [3:0]      strap_code;
    logic [3:0]      current_limit_strap_pin_code;
    logic [6:0]      base_addr;
    logic            offdis;
    logic [4:0][2:0] lfz;
    logic [6:0]      target;
    logic [2:0]      cap;
    logic [3:0]      overcurrent_limit;
    logic [15:0]     rdata;
    logic            rvalid;
    logic            done;
    logic            fail;
    logic            run;
  } scas_core_s;

  scas_core_s q, d;
  scas_if     ifc ();

  // ----------------------------------------
  // strap thermometer to code
  // ----------------------------------------
  // more thresholds tripped means a larger resistor; short gives zero
  function automatic logic [3:0] therm2code(input logic [14:0] t);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 15; i++) begin
      r = 4'(r + {3'b000, t[i]});
    end
    return r;
  endfunction

  logic [3:0] pin_offset;
  logic [2:0] lfz_idx;
  // clamp keeps pin offset inside the customer-programmable span;
  // a larger offset needs the disable bit and a base written by the host
  // clamping here rather than in the image keeps single and multi image alike
  assign pin_offset = (q.strap_code > MAX_PIN_OFFSET) ? MAX_PIN_OFFSET : q.strap_code;
  assign lfz_idx    = CURRENT_LIMIT_STRAP_PIN_LFZ_IDX[q.current_limit_strap_pin_code];

  // ----------------------------------------
  // register file and operating state
  // ----------------------------------------
  always_comb begin
    d        = q;
    d.rvalid = 1'b0;
    // strap levels caught once, the first cycle after reset release
    if (!q.strap_taken) begin
      d.strap_taken = 1'b1;
      d.strap_code  = therm2code(i_strap_select_pin);
      d.current_limit_strap_pin_code   = therm2code(i_current_limit_strap_pin);
    end
    // image contents land first; bus writes refused until load completes
    if (ifc.wr_valid) begin
      unique case (ifc.wr_idx)
        2'h0: d.base_addr = ifc.wr_data[6:0];
        2'h1: d.offdis    = ifc.wr_data[OFFDIS_BIT];
        2'h2: begin
          for (int k = 1; k < 5; k++) begin
            d.lfz[k] = ifc.wr_data[(k-1)*LFZ_FIELD_PITCH +: 3];
          end
        end
        2'h3: d.lfz[0] = ifc.wr_data[LFZ_IDX0_LSB +: 3];
      endcase
    end else if (i_reg_wr && q.done) begin
      if (i_reg_addr == REG_TARGET_ADDR) begin
        d.base_addr = i_reg_wdata[6:0];
      end
      if (i_reg_addr == REG_OFFSET_CTRL) begin
        d.offdis = i_reg_wdata[OFFDIS_BIT];
      end
      if (i_reg_addr == REG_LFZ_IDX1_4) begin
        for (int k = 1; k < 5; k++) begin
          d.lfz[k] = i_reg_wdata[(k-1)*LFZ_FIELD_PITCH +: 3];
        end
      end
      if (i_reg_addr == REG_LFZ_IDX0) begin
        d.lfz[0] = i_reg_wdata[LFZ_IDX0_LSB +: 3];
      end
    end
    // read mux; unmapped and reserved bits read zero
    if (i_reg_rd) begin
      d.rvalid = 1'b1;
      d.rdata  = 16'h0000;
      if (i_reg_addr == REG_TARGET_ADDR) begin
        d.rdata[6:0] = q.base_addr;
      end
      if (i_reg_addr == REG_OFFSET_CTRL) begin
        d.rdata[OFFDIS_BIT] = q.offdis;
      end
      if (i_reg_addr == REG_LFZ_IDX1_4) begin
        for (int k = 1; k < 5; k++) begin
          d.rdata[(k-1)*LFZ_FIELD_PITCH +: 3] = q.lfz[k];
        end
      end
      if (i_reg_addr == REG_LFZ_IDX0) begin
        d.rdata[LFZ_IDX0_LSB +: 3] = q.lfz[0];
      end
    end
    // one target address serves both I2C and PMBus ports
    d.target = q.offdis ? q.base_addr : 7'(q.base_addr + {3'b000, pin_offset});
    // capacitance code n means n+1 pF
    d.cap    = q.lfz[lfz_idx];
    d.overcurrent_limit    = q.current_limit_strap_pin_code;
    d.done   = ifc.done;
    d.fail   = ifc.crc_fail;
    d.run    = ifc.done && !ifc.crc_fail;
  end

  // state register; reset loads only constants so release is clean
  // the strap flag clears here, so every reset re-reads both straps
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q        <= '0;
      q.base_addr <= RST_BASE_ADDR;
      q.offdis <= RST_OFFDIS;
      for (int k = 0; k < 5; k++) begin
        q.lfz[k] <= RST_LFZ_CAP[k];
      end
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // loader and port wiring
  // ----------------------------------------
  // loader waits for the latched strap so the image index never
  // sees a comparator still settling
  assign ifc.strap_valid = q.strap_taken;
  assign ifc.strap_code  = q.strap_code;
  assign ifc.mem_ack     = i_mem_ack;
  assign ifc.mem_data    = i_mem_data;

  scas_loader u_loader (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .ifc     (ifc.loader)
  );

  assign o_reg_rdata             = q.rdata;
  assign o_reg_rvalid            = q.rvalid;
  assign o_mem_req               = ifc.mem_req;
  assign o_mem_addr              = ifc.mem_addr;
  assign o_target_addr           = q.target;
  assign o_loop_filter_zero_cap  = q.cap;
  assign o_overcurrent_limit_sel = q.overcurrent_limit;
  assign o_load_done             = q.done;
  assign o_crc_fail              = q.fail;
  assign o_regulator_en          = q.run;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_lfz0_write: assert property (i_reg_wr && q.done && (i_reg_addr == REG_LFZ_IDX0)
    && (lfz_idx == 3'h0) && !i_reg_rd ##1 !i_reg_wr [*1] |=> ##1
    o_loop_filter_zero_cap == $past(i_reg_wdata[LFZ_IDX0_LSB +: 3], 3))
    else $error("idx0 capacitance not applied");
  a_ocp_kept: assert property (q.strap_taken && $past(q.strap_taken) |=>
    o_overcurrent_limit_sel == $past(q.current_limit_strap_pin_code))
    else $error("overcurrent selection disturbed");
  a_lfz_override: assert property (q.done && (lfz_idx != 3'h0) |=>
    o_loop_filter_zero_cap == $past(q.lfz[lfz_idx]))
    else $error("indexed capacitance not used");
  a_strap_open: assert property (!q.strap_taken && (&i_strap_select_pin) |=>
    q.strap_code == 4'hF) else $error("open strap not fifteen");
  a_strap_short: assert property (!q.strap_taken && !(|i_strap_select_pin) |=>
    q.strap_code == 4'h0) else $error("short strap not zero");
  a_strap_frozen: assert property (q.strap_taken |=> $stable(q.strap_code))
    else $error("strap code changed after capture");
  a_addr_offset: assert property (!q.offdis ##1 !q.offdis |->
    o_target_addr == 7'($past(q.base_addr) + $past(pin_offset)))
    else $error("offset address wrong");
  a_offset_limit: assert property (!q.offdis ##1 !q.offdis |->
    7'(o_target_addr - $past(q.base_addr)) <= 7'h04)
    else $error("pin offset beyond four");
  a_offset_disable: assert property (q.offdis |=> o_target_addr == $past(q.base_addr))
    else $error("offset not ignored");
  a_crc_gate: assert property (o_crc_fail |-> !o_regulator_en throughout o_crc_fail [*2])
    else $error("regulator enabled after crc error");
  a_run_needs_load: assert property ($rose(o_regulator_en) |-> $past(ifc.done) && o_load_done)
    else $error("regulator enabled without load");

  // ----------------------------------------
  // capture, register port and load checks
  // ----------------------------------------
  // strap code is the count of tripped comparators
  a_strap_count: assert property (!q.strap_taken |=>
    q.strap_code == 4'($countones($past(i_strap_select_pin))))
    else $error("strap code not comparator count");

  // current-limit code reaches its output two edges after capture
  a_ocp_capture: assert property (!q.strap_taken |=> ##1
    o_overcurrent_limit_sel == 4'($countones($past(i_current_limit_strap_pin, 2))))
    else $error("overcurrent code not passed through");

  // every read strobe gets exactly one answer pulse
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");

  a_read_single: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("spurious read answer");

  // base and disable fields read back where they are written
  a_base_readback: assert property (i_reg_rd && (i_reg_addr == REG_TARGET_ADDR) |=>
    o_reg_rdata == {9'h000, $past(q.base_addr)})
    else $error("base address read back wrong");

  a_offdis_readback: assert property (i_reg_rd && (i_reg_addr == REG_OFFSET_CTRL) |=>
    o_reg_rdata == {9'h000, $past(q.offdis), 6'h00})
    else $error("offset disable read back wrong");

  // bus writes before a good load must leave the fields alone
  a_write_refused: assert property (i_reg_wr && !q.done && !ifc.wr_valid |=>
    $stable(q.base_addr) && $stable(q.offdis))
    else $error("register write taken before load");

  // a failed check never reports done nor enables the regulator
  a_fail_no_done: assert property (o_crc_fail |-> !o_load_done && !o_regulator_en)
    else $error("crc failure with regulator enabled");

  a_run_after_load: assert property (!o_load_done |-> !o_regulator_en)
    else $error("regulator enabled before load");

  // index zero capacitance follows its own field
  a_cap_idx0: assert property (q.done && (lfz_idx == 3'h0) |=>
    o_loop_filter_zero_cap == $past(q.lfz[0]))
    else $error("index zero capacitance not used");

  // image address held while the store has not answered
  a_addr_held: assert property (o_mem_req && !i_mem_ack |=> $stable(o_mem_addr))
    else $error("store address moved without answer");

  // store released once the check word has been taken
  a_req_released: assert property (o_load_done |-> !o_mem_req)
    else $error("store still requested after load");

  c_load_ok:  cover property ($rose(o_regulator_en));
  c_load_bad: cover property ($rose(o_crc_fail));
  c_offdis:   cover property (q.done && i_reg_wr && (i_reg_addr == REG_OFFSET_CTRL));
  c_cap_8pf:  cover property (o_loop_filter_zero_cap == 3'h7);

endmodule

`default_nettype wire

// [tb/scas_store_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// image store model
// ----------------------------------------
module scas_store_model (
  // clock
  input  wire logic        i_clock,
  // read port
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  output logic             o_ack,
  output logic [15:0]      o_data
);
  logic [15:0] words [512];
  int          wait_cycles = 0;
  int          cnt         = 0;

  initial begin
    o_ack = 1'b0;
    o_data = 16'h0000;
  end

  // one ack pulse per word, then one idle cycle so the address can move
  always @(posedge i_clock) begin
    if (o_ack) begin
      o_ack <= 1'b0;
      o_data <= ~o_data; // data is not held once the word is taken
      cnt <= 0;
    end else if (i_req && cnt >= wait_cycles) begin
      o_ack <= 1'b1;
      o_data <= words[i_addr[8:0]];
    end else begin
      cnt <= i_req ? cnt + 1 : 0;
      o_data <= ~o_data;
    end
  end
endmodule

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb
  import scas_pkg::*;
;
  typedef struct {
    logic [3:0] strap;
    logic [3:0] current_limit_strap_pin;
    logic [3:0] count;
    logic [5:0] ptr;
    int         dly;
    logic [6:0] tgt;
  } scas_row_s;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        i_clock = 1'b0;
  logic        i_rstn = 1'b0;
  logic [14:0] strap_pin = 15'h0000;
  logic [14:0] current_limit_strap_pin_pin = 15'h0000;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic        o_reg_rvalid;
  logic        o_mem_req;
  logic [15:0] o_mem_addr;
  logic        mem_ack;
  logic [15:0] mem_data;
  logic [6:0]  o_target_addr;
  logic [2:0]  o_cap;
  logic [3:0]  o_ocl;
  logic        o_load_done;
  logic        o_crc_fail;
  logic        o_regulator_en;
  int          errors = 0;
  int          checked = 0;
  logic [6:0]  img;

  scas_top dut (
    .i_clock(i_clock), .i_rstn(i_rstn),
    .i_strap_select_pin(strap_pin), .i_current_limit_strap_pin(current_limit_strap_pin_pin),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(mem_ack),
    .i_mem_data(mem_data), .o_target_addr(o_target_addr),
    .o_loop_filter_zero_cap(o_cap), .o_overcurrent_limit_sel(o_ocl),
    .o_load_done(o_load_done), .o_crc_fail(o_crc_fail), .o_regulator_en(o_regulator_en)
  );

  scas_store_model mem (
    .i_clock(i_clock), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .o_ack(mem_ack), .o_data(mem_data)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    forever #5 i_clock = ~i_clock;
  end

  task automatic complete_run();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  function automatic logic [14:0] therm(input logic [3:0] n);
    return 15'(16'h7FFF >> (4'hF - n));
  endfunction

  // reference crc, bit-serial, msb first
  function automatic logic [15:0] crc16(input logic [63:0] m);
    logic [15:0] c;
    c = CRC_INIT;
    for (int b = 63; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  function automatic logic [2:0] lfz_exp(input logic [2:0] k);
    logic [15:0] w;
    w = 16'h7531;
    return (k == 3'h0) ? 3'h2 : w[4*(k-1) +: 3];
  endfunction

  // every image: own base address, fixed filter fields, crc (broken if bad)
  task automatic fill(input logic bad);
    logic [63:0] m;
    for (int i = 0; i < 20; i++) begin
      m = {16'h0020 + 16'(i), 16'h0000, 16'h7531, 16'h2000};
      mem.words[1+5*i] = m[63:48];
      mem.words[2+5*i] = 16'h0000;
      mem.words[3+5*i] = 16'h7531;
      mem.words[4+5*i] = 16'h2000;
      mem.words[5+5*i] = crc16(m) ^ {15'h0000, bad};
    end
  endtask

  task automatic boot(input scas_row_s r);
    int n;
    n = 0;
    mem.words[0] = {2'h0, r.ptr, 4'h0, r.count};
    mem.wait_cycles = r.dly;
    @(posedge i_clock);
    i_rstn <= 1'b0;
    strap_pin <= therm(r.strap);
    current_limit_strap_pin_pin <= therm(r.current_limit_strap_pin);
    repeat (4) @(posedge i_clock);
    chk(16'(o_regulator_en), 16'h0000);
    chk(16'(o_mem_req), 16'h0000);
    i_rstn <= 1'b1;
    while (o_load_done !== 1'b1 && o_crc_fail !== 1'b1 && n < 300) begin
      @(posedge i_clock);
      n++;
    end
    @(negedge i_clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    @(negedge i_clock);
    chk(16'(o_reg_rvalid), 16'h0001);
    chk(o_reg_rdata, e);
  endtask

  // ----------------------------------------
  // cases: strap, current_limit_strap_pin, count, pointer, store wait, target
  // ----------------------------------------
  scas_row_s rows [7] = '{
    '{4'h0, 4'h0, 4'h1, 6'h02, 0, 7'h22},
    '{4'h3, 4'h1, 4'h1, 6'h02, 2, 7'h25},
    '{4'h3, 4'h2, 4'h5, 6'h00, 0, 7'h26},
    '{4'h4, 4'h8, 4'h5, 6'h01, 3, 7'h29},
    '{4'h7, 4'h9, 4'h8, 6'h00, 1, 7'h2B},
    '{4'hF, 4'hE, 4'hF, 6'h00, 0, 7'h33},
    '{4'h5, 4'h0, 4'h0, 6'h03, 0, 7'h27}};

  // watchdog sized well above eight boots and the register traffic
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  initial begin
    fill(1'b0);
    foreach (rows[i]) begin
      boot(rows[i]);
      img = (rows[i].count > 4'h1) ? 7'(rows[i].ptr + rows[i].strap) : 7'(rows[i].ptr);
      chk(16'(o_target_addr), 16'(rows[i].tgt));
      chk(16'(o_load_done), 16'h0001);
      chk(16'(o_regulator_en), 16'h0001);
      chk(16'(o_ocl), 16'(rows[i].current_limit_strap_pin));
      chk(16'(o_cap), 16'(lfz_exp(CURRENT_LIMIT_STRAP_PIN_LFZ_IDX[rows[i].current_limit_strap_pin])));
      rd(REG_TARGET_ADDR, 16'h0020 + 16'(img));
      chk(o_mem_addr, 16'h0005 + 16'h0005 * 16'(img));
      chk(16'(o_mem_req), 16'h0000);
    end
    rd(REG_LFZ_IDX1_4, 16'h7531);
    rd(8'h50, 16'h0000);
    // strap moves after power-up: offset must stay latched
    @(posedge i_clock);
    strap_pin <= therm(4'h0);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk(16'(o_target_addr), 16'h0027);
    wr(REG_OFFSET_CTRL, 16'h0040);
    chk(16'(o_target_addr), 16'h0023);
    wr(REG_TARGET_ADDR, 16'h0005);
    chk(16'(o_target_addr), 16'h0005);
    wr(REG_OFFSET_CTRL, 16'h0000);
    chk(16'(o_target_addr), 16'h0009);
    for (int v = 0; v < 8; v++) begin
      wr(REG_LFZ_IDX0, {1'b0, 3'(v), 12'h000});
      chk(16'(o_cap), 16'(v));
      chk(16'(o_ocl), 16'h0000);
      rd(REG_LFZ_IDX0, {1'b0, 3'(v), 12'h000});
    end
    // corrupted check word must keep the regulator off
    fill(1'b1);
    boot(rows[2]);
    chk(16'(o_crc_fail), 16'h0001);
    chk(16'(o_regulator_en), 16'h0000);
    chk(16'(o_load_done), 16'h0000);
    // writes after a failed load are refused
    wr(REG_TARGET_ADDR, 16'h0001);
    chk(16'(o_target_addr), 16'h0026);
    complete_run();
  end
endmodule

`default_nettype wire
